// [verilog/asp_cfg.svh]
// offsets, field positions and reset values of the serial port block
// assumes: included by bare name from the design file
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH

// register select codes carried by the comm byte
`define ASP_RS_STATUS 3'h0
`define ASP_RS_MODE 3'h1
`define ASP_RS_CONF 3'h2
`define ASP_RS_DATA 3'h3
`define ASP_RS_ID 3'h4
`define ASP_RS_GPO 3'h5

// comm byte fields
`define ASP_COMM_WEN_BIT 7
`define ASP_COMM_RW_BIT 6
`define ASP_COMM_RS_MSB 5
`define ASP_COMM_RS_LSB 3

// config, gpo and status fields
`define ASP_CONF_REF_PAIR_SELECT_BIT 20
`define ASP_GPO_EN_LSB 4
`define ASP_STATUS_RDY_BIT 7

// reset values
`define ASP_MODE_RST 24'h000000
`define ASP_CONF_RST 24'h000000
`define ASP_GPO_RST 8'h00

`endif

// [verilog/asp_pkg.sv]
// types shared by the serial port block
// assumes: nothing beyond the compile order
package asp_pkg;
   typedef enum logic [1:0] {
      ST_COMM = 2'b00,
      ST_READ = 2'b01,
      ST_WRITE = 2'b10
   } asp_state_e;
   typedef logic [2:0] asp_rs_t;
endpackage

// [verilog/asp_serial_port.sv]
// pin-level serial port, ready flag, sync reset and gpo pins of the converter
// assumes: host drives sclk, csN, din, syncN asynchronously; converter side on clk
`timescale 1ns/10ps
`include "asp_cfg.svh"

module asp_serial_port #(
   parameter int DATA_W = 24,
   // arbitrary identity value
   parameter logic [7:0] ID_VAL = 8'h5a
) (
   // system
   input wire logic clk,
   input wire logic rst_n,
   // serial pins
   input wire logic sclk,
   input wire logic csN,
   input wire logic din,
   output logic doutRdy,
   output logic doutRdyOe,
   // sync pin
   input wire logic syncN,
   // converter side
   input wire logic convDone,
   input wire logic [DATA_W-1:0] convData,
   input wire logic updateWarn,
   output logic filtRst,
   output logic calRst,
   output logic modRst,
   output logic [DATA_W-1:0] modeReg,
   output logic [DATA_W-1:0] confReg,
   output logic refPairSelect,
   // gpo pins
   output logic gpo0OrRef2Neg,
   output logic gpo0OrRef2NegOe,
   output logic gpo1OrRef2Pos,
   output logic gpo1OrRef2PosOe,
   output logic gpoBit2,
   output logic gpoBit2Oe,
   output logic gpoBit3,
   output logic gpoBit3Oe
);
   localparam int CW = $clog2(DATA_W + 1);
   localparam logic [CW-1:0] LAST8 = CW'(7);
   localparam logic [CW-1:0] LASTW = CW'(DATA_W - 1);

   if (DATA_W < 9 || DATA_W > 32) begin : g_chk
      $error("DATA_W must lie between 9 and 32");
   end

   // pin synchronisers
   logic sclk1, sclkS, sclkD, cs1, csS, din1, dinS, sync1, syncS;
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sclk1 <= 1'b0;
         sclkS <= 1'b0;
         sclkD <= 1'b0;
         cs1 <= 1'b1;
         csS <= 1'b1;
         din1 <= 1'b0;
         dinS <= 1'b0;
         sync1 <= 1'b1;
         syncS <= 1'b1;
      end else begin
         sclk1 <= sclk;
         sclkS <= sclk1;
         sclkD <= sclkS;
         cs1 <= csN;
         csS <= cs1;
         din1 <= din;
         dinS <= din1;
         sync1 <= syncN;
         syncS <= sync1;
      end
   end

   logic csLow, sclkRise, sclkFall;
   assign csLow = !csS;
   assign sclkRise = sclkS && !sclkD;
   assign sclkFall = !sclkS && sclkD;

   // serial engine and registers
   asp_pkg::asp_state_e st_r, st_nxt;
   logic [CW-1:0] cnt_r, cnt_nxt;
   logic [DATA_W-1:0] inSh_r, inSh_nxt, outSh_r, outSh_nxt;
   logic outBit_r, outBit_nxt;
   asp_pkg::asp_rs_t rs_r, rs_nxt;
   logic [DATA_W-1:0] mode_r, mode_nxt, conf_r, conf_nxt;
   logic [7:0] gpo_r, gpo_nxt;
   logic [DATA_W-1:0] data_r, data_nxt;
   logic rdyN_r, rdyN_nxt;
   logic dataRd;
   logic [DATA_W-1:0] loadVal;
   logic [7:0] newComm;
   asp_pkg::asp_rs_t commRs;
   logic [CW-1:0] lastBit;

   assign newComm = {inSh_r[6:0], dinS};
   assign commRs = newComm[`ASP_COMM_RS_MSB:`ASP_COMM_RS_LSB];
   assign lastBit = (rs_r == `ASP_RS_MODE || rs_r == `ASP_RS_CONF ||
                     rs_r == `ASP_RS_DATA) ? LASTW : LAST8;

   always_comb begin
      loadVal = '0;
      unique case (commRs)
         `ASP_RS_STATUS: loadVal[DATA_W-1 -: 8] = {rdyN_r, 7'h00};
         `ASP_RS_MODE: loadVal = mode_r;
         `ASP_RS_CONF: loadVal = conf_r;
         `ASP_RS_DATA: loadVal = data_r;
         `ASP_RS_ID: loadVal[DATA_W-1 -: 8] = ID_VAL;
         `ASP_RS_GPO: loadVal[DATA_W-1 -: 8] = gpo_r;
         default: loadVal = '0;
      endcase
   end

   // no sync term in the engine
   always_comb begin
      st_nxt = st_r;
      cnt_nxt = cnt_r;
      inSh_nxt = inSh_r;
      outSh_nxt = outSh_r;
      outBit_nxt = outBit_r;
      rs_nxt = rs_r;
      mode_nxt = mode_r;
      conf_nxt = conf_r;
      gpo_nxt = gpo_r;
      dataRd = 1'b0;
      if (!csLow) begin
         st_nxt = asp_pkg::ST_COMM;
         cnt_nxt = '0;
      end else if (sclkRise) begin
         inSh_nxt = {inSh_r[DATA_W-2:0], dinS};
         cnt_nxt = cnt_r + 1'b1;
         unique case (st_r)
            asp_pkg::ST_COMM: begin
               if (cnt_r == LAST8) begin
                  cnt_nxt = '0;
                  if (!newComm[`ASP_COMM_WEN_BIT]) begin
                     rs_nxt = commRs;
                     if (newComm[`ASP_COMM_RW_BIT]) begin
                        st_nxt = asp_pkg::ST_READ;
                        outSh_nxt = loadVal;
                     end else if (commRs == `ASP_RS_MODE || commRs == `ASP_RS_CONF ||
                                  commRs == `ASP_RS_GPO) begin
                        st_nxt = asp_pkg::ST_WRITE;
                     end
                  end
               end
            end
            asp_pkg::ST_WRITE: begin
               if (cnt_r == lastBit) begin
                  st_nxt = asp_pkg::ST_COMM;
                  cnt_nxt = '0;
                  if (rs_r == `ASP_RS_MODE) begin
                     mode_nxt = inSh_nxt;
                  end else if (rs_r == `ASP_RS_CONF) begin
                     conf_nxt = inSh_nxt;
                  end else begin
                     gpo_nxt = inSh_nxt[7:0];
                  end
               end
            end
            asp_pkg::ST_READ: begin
               if (cnt_r == lastBit) begin
                  st_nxt = asp_pkg::ST_COMM;
                  cnt_nxt = '0;
                  dataRd = (rs_r == `ASP_RS_DATA);
               end
            end
            default: st_nxt = asp_pkg::ST_COMM;
         endcase
      end else if (sclkFall && st_r == asp_pkg::ST_READ) begin
         outBit_nxt = outSh_r[DATA_W-1];
         outSh_nxt = {outSh_r[DATA_W-2:0], 1'b0};
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         st_r <= asp_pkg::ST_COMM;
         cnt_r <= '0;
         inSh_r <= '0;
         outSh_r <= '0;
         outBit_r <= 1'b1;
         rs_r <= `ASP_RS_STATUS;
         mode_r <= `ASP_MODE_RST;
         conf_r <= `ASP_CONF_RST;
         gpo_r <= `ASP_GPO_RST;
      end else begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         inSh_r <= inSh_nxt;
         outSh_r <= outSh_nxt;
         outBit_r <= outBit_nxt;
         rs_r <= rs_nxt;
         mode_r <= mode_nxt;
         conf_r <= conf_nxt;
         gpo_r <= gpo_nxt;
      end
   end

   // ready flag and result holding
   always_comb begin
      rdyN_nxt = rdyN_r;
      data_nxt = data_r;
      if (!syncS) begin
         rdyN_nxt = 1'b1;
      end else if (convDone) begin
         rdyN_nxt = 1'b0;
         data_nxt = convData;
      end else if (updateWarn || dataRd) begin
         rdyN_nxt = 1'b1;
      end
   end

   // filter, calibration and modulator reset
   logic rstHold_r, rstHold_nxt;
   always_comb begin
      rstHold_nxt = !syncS;
   end

   // dout pin
   logic dout_r, dout_nxt, doutOe_r, doutOe_nxt;
   always_comb begin
      doutOe_nxt = csLow;
      dout_nxt = (csLow && st_r == asp_pkg::ST_READ) ? outBit_r : rdyN_r;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rdyN_r <= 1'b1;
         data_r <= '0;
         rstHold_r <= 1'b0;
         dout_r <= 1'b1;
         doutOe_r <= 1'b0;
      end else begin
         rdyN_r <= rdyN_nxt;
         data_r <= data_nxt;
         rstHold_r <= rstHold_nxt;
         dout_r <= dout_nxt;
         doutOe_r <= doutOe_nxt;
      end
   end

   assign filtRst = rstHold_r;
   assign calRst = rstHold_r;
   assign modRst = rstHold_r;
   assign doutRdy = dout_r;
   assign doutRdyOe = doutOe_r;
   assign modeReg = mode_r;
   assign confReg = conf_r;
   assign refPairSelect = conf_r[`ASP_CONF_REF_PAIR_SELECT_BIT];

   // gpo pin drivers
   logic [3:0] gpoOut, gpoOe;
   for (genvar i = 0; i < 4; i++) begin : g_gpo
      assign gpoOut[i] = gpo_r[i];
      assign gpoOe[i] = gpo_r[`ASP_GPO_EN_LSB + i] && !(i < 2 && refPairSelect);
   end
   assign gpo0OrRef2Neg = gpoOut[0];
   assign gpo0OrRef2NegOe = gpoOe[0];
   assign gpo1OrRef2Pos = gpoOut[1];
   assign gpo1OrRef2PosOe = gpoOe[1];
   assign gpoBit2 = gpoOut[2];
   assign gpoBit2Oe = gpoOe[2];
   assign gpoBit3 = gpoOut[3];
   assign gpoBit3Oe = gpoOe[3];

   // checks
   sequence fallRead;
      csLow && st_r == asp_pkg::ST_READ && sclkFall;
   endsequence
   sequence commRead;
      csLow && sclkRise && st_r == asp_pkg::ST_COMM && cnt_r == LAST8 &&
         !newComm[`ASP_COMM_WEN_BIT] && newComm[`ASP_COMM_RW_BIT];
   endsequence
   sequence gpoWrite;
      csLow && sclkRise && st_r == asp_pkg::ST_WRITE && rs_r == `ASP_RS_GPO &&
         cnt_r == LAST8;
   endsequence

   conv_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
      !syncS |=> filtRst && calRst && modRst)
      else $error("converter not held in reset during sync");
   sync_indep_a: assert property (@(posedge clk) disable iff (!rst_n)
      !syncS && csLow && !sclkRise && !sclkFall |=> $stable(st_r) && $stable(outSh_r))
      else $error("sync disturbed the serial engine");
   rdy_force_a: assert property (@(posedge clk) disable iff (!rst_n)
      !syncS |=> rdyN_r ##1 (!doutRdyOe || $past(st_r) == asp_pkg::ST_READ || doutRdy))
      else $error("ready not forced high by sync");
   rdy_low_a: assert property (@(posedge clk) disable iff (!rst_n)
      convDone && syncS |=> !rdyN_r && data_r == $past(convData))
      else $error("ready not low after conversion");
   rdy_release_a: assert property (@(posedge clk) disable iff (!rst_n)
      updateWarn && !convDone |=> rdyN_r)
      else $error("ready not released before update");
   dout_fall_a: assert property (@(posedge clk) disable iff (!rst_n)
      fallRead ##1 (csLow && st_r == asp_pkg::ST_READ) |=>
         doutRdy == $past(outSh_r[DATA_W-1], 2))
      else $error("output bit not placed after falling edge");
   load_out_a: assert property (@(posedge clk) disable iff (!rst_n)
      commRead |=> outSh_r == $past(loadVal) && st_r == asp_pkg::ST_READ)
      else $error("output shifter not loaded from register");
   write_reg_a: assert property (@(posedge clk) disable iff (!rst_n)
      gpoWrite |=> gpo_r == $past({inSh_r[6:0], dinS}))
      else $error("written bits not transferred");
   ref_pins_a: assert property (@(posedge clk) disable iff (!rst_n)
      conf_r[`ASP_CONF_REF_PAIR_SELECT_BIT] |-> !gpo1OrRef2PosOe && !gpo0OrRef2NegOe)
      else $error("gpo pin driven while reference pair selected");
   gpo_static_a: assert property (@(posedge clk) disable iff (!rst_n)
      $stable(gpo_r) |-> $stable({gpoBit3, gpoBit2, gpoBit3Oe, gpoBit2Oe}))
      else $error("static gpo pins changed without a write");
endmodule

// [sim/asp_host_model.sv]
// host side serial master driving the converter's serial pins
// assumes: bench clock on clk; sclk idles high, steps on clk falling edges
`timescale 1ns/10ps

module asp_host_model (
   // bench clock
   input wire logic clk,
   // serial pins
   output logic sclk,
   output logic csN,
   output logic din,
   input wire logic doutRdy
);
   initial begin
      sclk = 1'b1;
      csN = 1'b1;
      din = 1'b0;
   end

   // select or release; released din shows the inverse level
   task automatic sel(input logic on);
      @(negedge clk);
      csN = ~on;
      if (!on) din = ~din;
      repeat (4) @(negedge clk);
   endtask

   // shift at fall, sample at rise
   task automatic shift(input logic [31:0] tx, input int n, output logic [31:0] rx);
      rx = '0;
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk);
         sclk = 1'b0;
         din = tx[i];
         repeat (5) @(negedge clk);
         sclk = 1'b1;
         rx = {rx[30:0], doutRdy};
         repeat (2) @(negedge clk);
      end
   endtask
endmodule

// [sim/testbench.sv]
// self-checking bench of the converter serial port
// assumes: host model drives the serial pins; bench plays the converter side
`timescale 1ns/10ps

module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic sclk, csN, din, doutRdy, doutRdyOe;
   logic syncN = 1'b1;
   logic convDone = 1'b0;
   logic updateWarn = 1'b0;
   logic [23:0] convData = '0;
   logic [23:0] modeReg, confReg;
   logic filtRst, calRst, modRst, refPairSelect;
   logic g0, g0Oe, g1, g1Oe, g2, g2Oe, g3, g3Oe;
   int errCount = 0;
   int nCompared = 0;
   int cycles = 0;
   logic [31:0] seed = 32'h000184fb;
   logic [31:0] rx, expMode, expConf, expGpo;
   // arbitrary identity value, handed to the design as well
   localparam logic [7:0] idVal = 8'h5a;
   // behavioural register model, indexed by select code
   int mdl [8];

   always #20 clk = ~clk;

   asp_serial_port #(.DATA_W(24), .ID_VAL(idVal)) dut (.clk(clk), .rst_n(rst_n), .sclk(sclk),
      .csN(csN), .din(din), .doutRdy(doutRdy), .doutRdyOe(doutRdyOe), .syncN(syncN),
      .convDone(convDone), .convData(convData), .updateWarn(updateWarn),
      .filtRst(filtRst), .calRst(calRst), .modRst(modRst), .modeReg(modeReg),
      .confReg(confReg), .refPairSelect(refPairSelect), .gpo0OrRef2Neg(g0),
      .gpo0OrRef2NegOe(g0Oe), .gpo1OrRef2Pos(g1), .gpo1OrRef2PosOe(g1Oe),
      .gpoBit2(g2), .gpoBit2Oe(g2Oe), .gpoBit3(g3), .gpoBit3Oe(g3Oe));

   asp_host_model host (.clk(clk), .sclk(sclk), .csN(csN), .din(din), .doutRdy(doutRdy));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         errCount++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compared %0d mismatches %0d", nCompared, errCount);
      if (errCount == 0 && nCompared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic xfer(input logic [31:0] c, input logic [31:0] d, input int n);
      host.sel(1'b1);
      host.shift(c, 8, rx);
      host.shift(d, n, rx);
      host.sel(1'b0);
      repeat (4) @(negedge clk);
      if (c[7:6] == 2'h0 && c[5:3] inside {3'h1, 3'h2, 3'h5}) mdl[c[5:3]] = d;
   endtask

   // result pulse from the converter, ready must fall
   task automatic conv();
      @(negedge clk);
      convData = 24'(rnd());
      mdl[3] = convData;
      convDone = 1'b1;
      @(negedge clk);
      convDone = 1'b0;
      repeat (3) @(negedge clk);
      chk(doutRdy, 1'b0);
      xfer(8'h40, 0, 8);
      chk(rx, 8'h00);
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         summarize();
      end
   end

   initial begin
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      chk({doutRdy, doutRdyOe, filtRst, calRst, modRst}, 5'h10);
      xfer(8'h60, 0, 8);
      chk(rx, idVal);
      for (int i = 0; i < 4; i++) begin
         expConf = rnd() & 32'hffffff;
         expConf[20] = i[0];
         xfer(8'h10, expConf, 24);
         chk(confReg, expConf);
         chk(refPairSelect, expConf[20]);
         expGpo = rnd() & 32'hff;
         xfer(8'h28, expGpo, 8);
         chk({g3Oe, g2Oe, g1Oe, g0Oe}, expGpo[7:4] & (i[0] ? 4'hc : 4'hf));
         chk({g1, g0}, expGpo[1:0]);
         chk({g3, g2}, expGpo[3:2]);
         expMode = rnd() & 32'hffffff;
         xfer(8'h08, expMode, 24);
         chk(modeReg, expMode);
         xfer(8'h48, 0, 24);
         chk(rx, mdl[1]);
         xfer(8'h50, 0, 24);
         chk(rx, mdl[2]);
         xfer(8'h68, 0, 8);
         chk(rx, mdl[5]);
         conv();
         if (i[0]) begin
            xfer(8'h58, 0, 24);
            chk(rx, mdl[3]);
            chk(doutRdy, 1'b1);
         end else begin
            @(negedge clk);
            updateWarn = 1'b1;
            @(negedge clk);
            updateWarn = 1'b0;
            repeat (3) @(negedge clk);
            chk(doutRdy, 1'b1);
            xfer(8'h40, 0, 8);
            chk(rx, 8'h80);
         end
      end
      conv();
      expMode = rnd() & 32'hffffff;
      // sync pulse lands in the comm byte of a mode write
      fork
         xfer(8'h08, expMode, 24);
         begin
            repeat (60) @(negedge clk);
            syncN = 1'b0;
            repeat (6) @(negedge clk);
            chk({filtRst, calRst, modRst}, 3'h7);
            chk(doutRdy, 1'b1);
            syncN = 1'b1;
         end
      join
      chk(modeReg, mdl[1]);
      chk({filtRst, calRst, modRst}, 3'h0);
      summarize();
   end
endmodule
